// [design/tmr8_edge_sync.sv]
`timescale 1ns/10ps
module tmr8_edge_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pin,
  output logic o_rise,
  output logic o_fall
);

  logic sync0;
  logic sync1;
  logic prev;

  // idle high so a high pin at release is not seen as an edge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync0 <= 1'b1;
      sync1 <= 1'b1;
      prev <= 1'b1;
    end else begin
      sync0 <= i_pin;
      sync1 <= sync0;
      prev <= sync1;
    end
  end

  assign o_rise = sync1 & ~prev;
  assign o_fall = prev & ~sync1;

endmodule

// [design/tmr8_prescale.sv]
`timescale 1ns/10ps
module tmr8_prescale #(
  parameter int W = 11
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_en,
  output logic [W:0] o_tick
);

  initial begin
    if (W < 1) begin
      $error("prescaler width must be at least one");
    end
  end

  logic [W-1:0] cnt;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt <= '0;
    end else if (i_en) begin
      cnt <= cnt + 1'b1;
    end
  end

  // tap k pulses once every 2^k input enables
  assign o_tick[0] = i_en;
  for (genvar k = 1; k <= W; k++) begin : g_tap
    assign o_tick[k] = i_en & (&cnt[k-1:0]);
  end

endmodule

// [design/tmr8_top.sv]
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
// Summary of operation
// RL1 - timer mode counts source ticks, match raises interrupt, clears, keeps counting
// RL2 - double buffered compare write while running applies at next match
// RL3 - unbuffered compare below count takes effect, match only after wrap
// RL4 - unbuffered compare equal to count matches right after the write
// RL5 - compare write while stopped updates active value at once
// RL6 - compare read returns the last written value
// RL7 - clock select picks gear divisions or subclock sixteenth and eighth
// RL8 - low speed modes allow codes 000, 001, 111 only; 111 gives subclock/4
// RL9 - event mode when op 00, cascade 0, external input select 1
// RL10 - event mode counts input falling edges, match interrupts and clears
// RL11 - clearing run bit stops counting and zeroes the counter
// RL12 - mode register writes are ignored while running
// RL13 - event source stays slow enough with four cycle high and low phases
// RL14 - double buffer enable bit buffers compare in event mode too
// RL15 - pwm of 7-bit duty with extra pulse on even duty pulses
// RL16 - pwm mode when op 10, cascade 0, external input select 0
// RL17 - pwm register holds duty in 7..1, extra pulse in 0, resets ones
// RL18 - event input synchronised, falling edge is sampled high then low
module tmr8_top #(
  parameter int CNT_W = 8
) (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_EVENT_IN,
  input wire logic I_SUB_CLK,
  output logic O_IRQ,
  output logic O_PWM
);

  initial begin
    if (CNT_W != 8) begin
      $error("counter width must be 8");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  tmr8_pkg::tmr8_mode_t mode;
  tmr8_pkg::tmr8_sys_t sys;
  tmr8_pkg::tmr8_run_t state;
  logic casc;
  logic [7:0] cmp_buf;
  logic [7:0] cmp_act;
  logic [7:0] pwm_buf;
  logic [7:0] pwm_act;
  logic [7:0] count;
  logic [0:0] sts;
  logic [0:0] msk;
  logic chk;
  logic pwm_cyc;
  logic ev_fall;
  logic sub_rise;
  logic [tmr8_pkg::GEAR_DIV_W:0] gear_t;
  logic [tmr8_pkg::SUB_DIV_W:0] sub_t;
  logic src_tick;
  logic tick;
  logic running;
  logic slow;
  logic sub_sel;
  logic is_event;
  logic is_timer;
  logic is_pwm;
  logic match;
  logic pwm_ovf;
  logic evt;
  logic wr_go;
  logic setup;
  logic [7:0] wbyte;
  logic [7:0] thresh;
  logic [31:0] next_rdata;
  logic next_err;

  ////////////////////////////////////////////////////////////////////////////
  // clock sources and input edges

  tmr8_prescale #(
    .W(tmr8_pkg::GEAR_DIV_W)
  ) u_gear_div (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_en(1'b1),
    .o_tick(gear_t)
  );

  tmr8_edge_sync u_sub_edge (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_pin(I_SUB_CLK),
    .o_rise(sub_rise),
    .o_fall()
  );

  tmr8_prescale #(
    .W(tmr8_pkg::SUB_DIV_W)
  ) u_sub_div (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_en(sub_rise),
    .o_tick(sub_t)
  );

  // RL18 synchronised falling edge
  tmr8_edge_sync u_ev_edge (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_pin(I_EVENT_IN),
    .o_rise(),
    .o_fall(ev_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode decode and source selection

  assign running = (state == tmr8_pkg::ST_RUN);
  assign slow = sys.low_speed | sys.sleep_low;
  assign sub_sel = sys.div_src | slow;
  // RL9 event mode decode
  assign is_event = ~casc & (mode.op == tmr8_pkg::OP_TIMER) & mode.ext_in;
  assign is_timer = ~casc & ~mode.ext_in &
                    ((mode.op == tmr8_pkg::OP_TIMER) | (mode.op == tmr8_pkg::OP_TIMER_ALT));
  // RL16 pwm mode decode
  assign is_pwm = ~casc & ~mode.ext_in & (mode.op == tmr8_pkg::OP_PWM);

  always_comb begin
    src_tick = 1'b0;
    case (mode.clk_sel)
      // RL7 slow codes swap to subclock
      3'h0: src_tick = sub_sel ? sub_t[4] : gear_t[11];
      3'h1: src_tick = sub_sel ? sub_t[3] : gear_t[10];
      // RL8 no clock in low speed
      3'h2: src_tick = slow ? 1'b0 : gear_t[8];
      3'h3: src_tick = slow ? 1'b0 : gear_t[6];
      3'h4: src_tick = slow ? 1'b0 : gear_t[4];
      3'h5: src_tick = slow ? 1'b0 : gear_t[2];
      3'h6: src_tick = slow ? 1'b0 : gear_t[1];
      // RL8 low speed gets subclock/4
      3'h7: src_tick = slow ? sub_t[2] : gear_t[0];
      default: src_tick = 1'b0;
    endcase
  end

  // RL10 event edges drive the count
  assign tick = running & (is_event ? ev_fall : ((is_timer | is_pwm) & src_tick));

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  assign setup = I_PSEL & ~I_PENABLE;
  assign wr_go = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
  assign wbyte = I_PWDATA[7:0];

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    case (I_PADDR)
      tmr8_pkg::ADDR_MODE: next_rdata[7:0] = mode;
      tmr8_pkg::ADDR_CTRL: begin
        next_rdata[tmr8_pkg::CTRL_RUN_BIT] = running;
        next_rdata[tmr8_pkg::CTRL_CASC_BIT] = casc;
      end
      // RL6 read gives last written
      tmr8_pkg::ADDR_CMP: next_rdata[7:0] = cmp_buf;
      tmr8_pkg::ADDR_COUNT: next_rdata[7:0] = count;
      tmr8_pkg::ADDR_SYS: next_rdata[2:0] = sys;
      tmr8_pkg::ADDR_STS: next_rdata[0] = sts[0];
      tmr8_pkg::ADDR_MSK: next_rdata[0] = msk[0];
      tmr8_pkg::ADDR_PWM: next_rdata[7:0] = pwm_buf;
      default: next_err = 1'b1;
    endcase
  end

  // one wait-free access cycle; data latched at the setup edge
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_PREADY <= 1'b0;
      O_PRDATA <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY <= setup;
      if (setup) begin
        O_PRDATA <= I_PWRITE ? 32'h0000_0000 : next_rdata;
        O_PSLVERR <= next_err;
      end else begin
        O_PSLVERR <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      mode <= tmr8_pkg::MODE_RST;
    // RL12 mode frozen while running
    end else if (wr_go && I_PADDR == tmr8_pkg::ADDR_MODE && !running) begin
      mode <= wbyte;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      state <= tmr8_pkg::ST_STOP;
      casc <= 1'b0;
    end else if (wr_go && I_PADDR == tmr8_pkg::ADDR_CTRL) begin
      state <= wbyte[tmr8_pkg::CTRL_RUN_BIT] ? tmr8_pkg::ST_RUN : tmr8_pkg::ST_STOP;
      casc <= wbyte[tmr8_pkg::CTRL_CASC_BIT];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      sys <= tmr8_pkg::SYS_RST;
    end else if (wr_go && I_PADDR == tmr8_pkg::ADDR_SYS) begin
      sys <= wbyte[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare value

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      cmp_buf <= tmr8_pkg::CMP_RST;
      cmp_act <= tmr8_pkg::CMP_RST;
    end else begin
      if (wr_go && I_PADDR == tmr8_pkg::ADDR_CMP) begin
        cmp_buf <= wbyte;
      end
      // RL5 stopped writes go straight through
      // RL3 unbuffered writes take effect at once
      if (wr_go && I_PADDR == tmr8_pkg::ADDR_CMP && (!running || !mode.dbuf)) begin
        cmp_act <= wbyte;
      // RL2 buffered value loads on match, even beside a new write
      // RL14 same buffering for event mode
      end else if (match && mode.dbuf) begin
        cmp_act <= cmp_buf;
      end
    end
  end

  // compare only right after a count step or an unbuffered write,
  // so a held count never re-matches every cycle
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      chk <= 1'b0;
    end else begin
      // RL4 check right after equal write
      chk <= tick | (wr_go && I_PADDR == tmr8_pkg::ADDR_CMP && running && !mode.dbuf);
    end
  end

  assign match = chk & running & (is_timer | is_event) & (count == cmp_act);

  ////////////////////////////////////////////////////////////////////////////
  // up counter

  assign pwm_ovf = tick & is_pwm & (count[6:0] == tmr8_pkg::PWM_LAST);

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      count <= 8'h00;
    // RL11 stop clears counter
    end else if (!running) begin
      count <= 8'h00;
    // RL1 clear on match
    end else if (match) begin
      count <= 8'h00;
    end else if (pwm_ovf) begin
      count <= 8'h00;
    // RL1 count source ticks
    end else if (tick) begin
      count <= count + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      pwm_buf <= tmr8_pkg::PWM_RST;
      pwm_act <= tmr8_pkg::PWM_RST;
    end else if (wr_go && I_PADDR == tmr8_pkg::ADDR_PWM) begin
      pwm_buf <= wbyte;
      if (!running || !mode.dbuf) begin
        pwm_act <= wbyte;
      end
    end else if (pwm_ovf && pwm_cyc && mode.dbuf) begin
      pwm_act <= pwm_buf;
    end
  end

  // high for the second of each pair of periods
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      pwm_cyc <= 1'b0;
    end else if (!running || !is_pwm) begin
      pwm_cyc <= 1'b0;
    end else if (pwm_ovf) begin
      pwm_cyc <= ~pwm_cyc;
    end
  end

  // RL17 duty in 7..1, extra pulse in bit 0
  // RL15 extra count on even periods
  assign thresh = {1'b0, pwm_act[7:1]} + {7'h00, pwm_act[0] & pwm_cyc};

  // level compare; duty 127 plus extra never flips, a known limit
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_PWM <= 1'b0;
    end else if (running && is_pwm) begin
      O_PWM <= mode.out_level ^ ({1'b0, count[6:0]} >= thresh);
    end else begin
      O_PWM <= mode.out_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt

  // RL10 match event raises interrupt
  assign evt = match | (pwm_ovf & pwm_cyc);

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      sts <= tmr8_pkg::STS_RST;
    end else if (evt) begin
      sts[tmr8_pkg::STS_MATCH_BIT] <= 1'b1;
    end else if (wr_go && I_PADDR == tmr8_pkg::ADDR_STS && wbyte[tmr8_pkg::STS_MATCH_BIT]) begin
      sts[tmr8_pkg::STS_MATCH_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      msk <= tmr8_pkg::MSK_RST;
    end else if (wr_go && I_PADDR == tmr8_pkg::ADDR_MSK) begin
      msk <= wbyte[0:0];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |(sts & msk);
    end
  end

endmodule

// [pkg/tmr8_pkg.sv]
package tmr8_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_CMP = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0C;
  localparam logic [7:0] ADDR_SYS = 8'h10;
  localparam logic [7:0] ADDR_STS = 8'h14;
  localparam logic [7:0] ADDR_MSK = 8'h18;
  localparam logic [7:0] ADDR_PWM = 8'h28;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [7:0] PWM_RST = 8'hFF;
  localparam logic [2:0] SYS_RST = 3'h0;
  localparam logic [0:0] STS_RST = 1'h0;
  localparam logic [0:0] MSK_RST = 1'h0;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_CASC_BIT = 1;
  localparam int STS_MATCH_BIT = 0;

  // mode_control: out_level, dbuf, clk_sel, ext_in, op (bit 7 down to 0)
  typedef struct packed {
    logic out_level;
    logic dbuf;
    logic [2:0] clk_sel;
    logic ext_in;
    logic [1:0] op;
  } tmr8_mode_t;

  // system_control_one: sleep_low, low_speed, div_src (bit 2 down to 0)
  typedef struct packed {
    logic sleep_low;
    logic low_speed;
    logic div_src;
  } tmr8_sys_t;

  localparam logic [1:0] OP_TIMER = 2'h0;
  localparam logic [1:0] OP_TIMER_ALT = 2'h1;
  localparam logic [1:0] OP_PWM = 2'h2;

  typedef enum logic [1:0] {
    ST_STOP = 2'b00,
    ST_RUN = 2'b01
  } tmr8_run_t;

  ////////////////////////////////////////////////////////////////////////////
  // counts
  localparam int GEAR_DIV_W = 11;
  localparam int SUB_DIV_W = 4;
  localparam logic [6:0] PWM_LAST = 7'h7F;

endpackage

// [tb/tb.sv]
`timescale 1ns/10ps
module tb;
  logic I_CLK = 1'b0;
  logic I_SYS_RST = 1'b1;
  logic I_PSEL = 1'b0;
  logic I_PENABLE = 1'b0;
  logic I_PWRITE = 1'b0;
  logic [7:0] I_PADDR = 8'h00;
  logic [31:0] I_PWDATA = 32'h0;
  logic I_SUB_CLK = 1'b0;
  logic go = 1'b0;
  logic [31:0] O_PRDATA;
  logic O_PREADY;
  logic O_PSLVERR;
  logic O_IRQ;
  logic O_PWM;
  logic ev;
  logic busy;
  logic [31:0] r;
  logic e;
  int t;
  int bad_count = 0;
  int checks = 0;
  // system control, clock code, cycles per tick (0: no clock)
  int rows[12][3] = '{'{0, 0, 2048}, '{0, 1, 1024}, '{0, 2, 256}, '{0, 3, 64},
    '{0, 4, 16}, '{0, 5, 4}, '{0, 6, 2}, '{0, 7, 1}, '{1, 0, 128}, '{1, 1, 64},
    '{2, 7, 32}, '{2, 2, 0}};
  always #20 I_CLK = ~I_CLK;
  // subclock of eight cycles, slow enough to sync
  always begin
    repeat (4) @(posedge I_CLK);
    I_SUB_CLK <= ~I_SUB_CLK;
  end
  tmr8_top i_tmr8_top (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_EVENT_IN(ev),
    .I_SUB_CLK(I_SUB_CLK), .O_IRQ(O_IRQ), .O_PWM(O_PWM));
  tmr8_event_src i_tmr8_event_src (.i_clk(I_CLK), .i_go(go), .i_num(8'h05),
    .o_pin(ev), .o_busy(busy));
  ////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      bad_count++;
      $display("MISMATCH %0t seen %h want %h", $time, s, x);
    end
  endtask
  // idle cycle after each transfer keeps drivers single per step
  task automatic apb(input int w, input logic [7:0] a, input logic [7:0] d);
    I_PSEL <= 1'b1;
    I_PWRITE <= (w != 0);
    I_PADDR <= a;
    I_PWDATA <= {24'h0, d};
    @(posedge I_CLK);
    I_PENABLE <= 1'b1;
    do @(posedge I_CLK); while (O_PREADY !== 1'b1);
    r = O_PRDATA;
    e = O_PSLVERR;
    I_PSEL <= 1'b0;
    I_PENABLE <= 1'b0;
    @(posedge I_CLK);
  endtask
  task automatic wait_irq(input int lim);
    for (t = 0; t < lim && O_IRQ !== 1'b1; t++) @(posedge I_CLK);
  endtask
  task automatic stop_go(input logic [7:0] mode, input logic [7:0] cmp);
    apb(1, tmr8_pkg::ADDR_CTRL, 8'h00);
    apb(1, tmr8_pkg::ADDR_STS, 8'h01);
    apb(1, tmr8_pkg::ADDR_MODE, mode);
    apb(1, tmr8_pkg::ADDR_CMP, cmp);
    apb(1, tmr8_pkg::ADDR_CTRL, 8'h01);
  endtask
  // pulse the source, then let the last edge pass the synchroniser
  task automatic send_events;
    go <= 1'b1;
    @(posedge I_CLK);
    go <= 1'b0;
    @(posedge I_CLK);
    while (busy) @(posedge I_CLK);
    repeat (8) @(posedge I_CLK);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge I_CLK);
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge I_CLK);
    I_SYS_RST <= 1'b0;
    @(posedge I_CLK);
    apb(1, tmr8_pkg::ADDR_MSK, 8'h01);
    foreach (rows[i]) begin
      apb(1, tmr8_pkg::ADDR_SYS, 8'(rows[i][0]));
      stop_go(8'(rows[i][1] << 3), 8'h02);
      wait_irq(2 * rows[i][2] + 300 * (rows[i][2] == 0) + 20);
      check(O_IRQ === 1'b1 && t >= rows[i][2], rows[i][2] != 0);
    end
    apb(1, tmr8_pkg::ADDR_SYS, 8'h00);
    stop_go(8'h78, 8'h40);
    apb(1, tmr8_pkg::ADDR_MODE, 8'h00);
    apb(0, tmr8_pkg::ADDR_MODE, 8'h00);
    check(r, 32'h78);
    apb(1, tmr8_pkg::ADDR_CMP, 8'h03);
    apb(0, tmr8_pkg::ADDR_CMP, 8'h00);
    check(r, 32'h03);
    wait_irq(80);
    check(O_IRQ, 1'b1);
    stop_go(8'h38, 8'h40);
    repeat (10) @(posedge I_CLK);
    apb(1, tmr8_pkg::ADDR_CMP, 8'h03);
    wait_irq(150);
    check(O_IRQ, 1'b0);
    wait_irq(150);
    check(O_IRQ, 1'b1);
    // slowest code so the count holds between read and write
    stop_go(8'h00, 8'hFF);
    do apb(0, tmr8_pkg::ADDR_COUNT, 8'h00); while (r === 32'h0);
    apb(1, tmr8_pkg::ADDR_CMP, r[7:0]);
    wait_irq(10);
    check(O_IRQ, 1'b1);
    stop_go(8'h04, 8'h03);
    send_events();
    check(O_IRQ, 1'b1);
    apb(0, tmr8_pkg::ADDR_COUNT, 8'h00);
    check(r, 32'h02);
    // buffered four waits for the match at three: five events leave two, not one
    stop_go(8'h44, 8'h03);
    apb(1, tmr8_pkg::ADDR_CMP, 8'h04);
    send_events();
    apb(0, tmr8_pkg::ADDR_COUNT, 8'h00);
    check(r, 32'h02);
    apb(1, tmr8_pkg::ADDR_MSK, 8'h00);
    repeat (2) @(posedge I_CLK);
    check(O_IRQ, 1'b0);
    apb(1, tmr8_pkg::ADDR_MSK, 8'h01);
    repeat (2) @(posedge I_CLK);
    check(O_IRQ, 1'b1);
    stop_go(8'h3A, 8'h00);
    apb(1, tmr8_pkg::ADDR_CTRL, 8'h00);
    apb(0, tmr8_pkg::ADDR_COUNT, 8'h00);
    check(r, 32'h0);
    check(O_IRQ, 1'b0);
    // duty 16 with extra pulse: 112 then 111 high counts over two periods
    apb(1, tmr8_pkg::ADDR_PWM, 8'h21);
    apb(1, tmr8_pkg::ADDR_CTRL, 8'h01);
    t = 0;
    repeat (256) begin
      @(posedge I_CLK);
      t += (O_PWM === 1'b1);
    end
    check(t, 223);
    @(posedge I_CLK);
    check(O_IRQ, 1'b1);
    I_SYS_RST <= 1'b1;
    repeat (10) @(posedge I_CLK);
    I_SYS_RST <= 1'b0;
    @(posedge I_CLK);
    check({O_IRQ, O_PWM}, 2'b00);
    apb(0, tmr8_pkg::ADDR_PWM, 8'h00);
    check(r, 32'hFF);
    apb(0, tmr8_pkg::ADDR_MODE, 8'h00);
    check(r, 32'h00);
    apb(0, 8'h1C, 8'h00);
    check(e, 1'b1);
    check(r, 32'h0);
    complete_run();
  end
endmodule

// [tb/tmr8_event_src.sv]
`timescale 1ns/10ps
module tmr8_event_src (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [7:0] i_num,
  output logic o_pin,
  output logic o_busy
);
  logic [7:0] left = 8'h00;
  logic [2:0] ph = 3'h0;
  initial o_pin = 1'b1;
  assign o_busy = left != 8'h00;
  always @(posedge i_clk) begin
    o_pin <= !o_busy || ph[2];
    ph <= o_busy ? ph + 3'h1 : 3'h0;
    if (i_go) begin
      left <= i_num;
    end else if (o_busy && ph == 3'h7) begin
      left <= left - 8'h01;
    end
  end
endmodule

// [tb/tmr8_monitor.sv]
`timescale 1ns/10ps
module tmr8_monitor (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic I_EVENT_IN,
  input wire logic I_SUB_CLK,
  input wire logic O_IRQ,
  input wire logic O_PWM
);
  logic [7:0] last_cmp;
  logic [7:0] last_pwm;
  logic [7:0] last_mode;
  logic run;
  wire setup = I_PSEL && !I_PENABLE;
  wire rd = setup && !I_PWRITE;
  wire wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
  ////////////////////////////////////////
  // shadows of what software last wrote, mode only from writes made while stopped
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      last_cmp <= tmr8_pkg::CMP_RST;
      last_pwm <= tmr8_pkg::PWM_RST;
      last_mode <= tmr8_pkg::MODE_RST;
      run <= 1'b0;
    end else if (wr) begin
      if (I_PADDR == tmr8_pkg::ADDR_CMP) last_cmp <= I_PWDATA[7:0];
      if (I_PADDR == tmr8_pkg::ADDR_PWM) last_pwm <= I_PWDATA[7:0];
      if (I_PADDR == tmr8_pkg::ADDR_MODE && !run) last_mode <= I_PWDATA[7:0];
      if (I_PADDR == tmr8_pkg::ADDR_CTRL) run <= I_PWDATA[0];
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  chk_ready_after_setup: assert property (setup |=> O_PREADY)
    else $error("no ready after setup");
  chk_ready_one_cycle: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready too long");
  chk_unmapped_error: assert property (setup && I_PADDR == 8'h1C
    |=> O_PSLVERR && (I_PWRITE || O_PRDATA == 32'h0)) else $error("unmapped not refused");
  chk_cmp_readback: assert property (
    rd && I_PADDR == tmr8_pkg::ADDR_CMP |=> O_PRDATA == {24'h0, last_cmp})
    else $error("compare readback");
  chk_pwm_readback: assert property (
    rd && I_PADDR == tmr8_pkg::ADDR_PWM |=> O_PRDATA == {24'h0, last_pwm})
    else $error("pwm readback");
  chk_mode_locked: assert property (
    rd && I_PADDR == tmr8_pkg::ADDR_MODE |=> O_PRDATA == {24'h0, last_mode})
    else $error("mode changed while running");
  chk_stop_clears: assert property (
    rd && I_PADDR == tmr8_pkg::ADDR_COUNT && !run |=> O_PRDATA == 32'h0)
    else $error("count not zero when stopped");
  chk_irq_masked: assert property (
    wr && I_PADDR == tmr8_pkg::ADDR_MSK && !I_PWDATA[0] |=> ##1 !O_IRQ)
    else $error("irq while masked");
  cover property ($rose(O_IRQ));
  cover property ($rose(O_PWM));
  cover property (setup && I_PADDR == 8'h1C);
endmodule
bind tmr8_top tmr8_monitor i_tmr8_monitor (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .I_EVENT_IN(I_EVENT_IN), .I_SUB_CLK(I_SUB_CLK), .O_IRQ(O_IRQ), .O_PWM(O_PWM));
